//--- inc/scsc_map.vh
// Register map, field positions and timing constants of the switch control slave
`ifndef SCSC_MAP_VH
`define SCSC_MAP_VH

// Slave address: fixed upper six bits, LSB from the select pin
`define SCSC_DEV_ADR_HI 6'h24

// Register offsets
`define SCSC_OFS_FAST 8'h00
`define SCSC_OFS_SIDE 8'h01
`define SCSC_OFS_INSET 8'h10
`define SCSC_OFS_PULSE 8'h11
`define SCSC_OFS_BOOST 8'h13
`define SCSC_OFS_OUTSET 8'h20

// Reset values
`define SCSC_RST_FAST 8'h40
`define SCSC_RST_SIDE 8'h40
`define SCSC_RST_INSET 8'h01
`define SCSC_RST_PULSE 8'h00
`define SCSC_RST_BOOST 8'h00
`define SCSC_RST_OUTSET 8'h03

// Implemented bits of each register
`define SCSC_MSK_FAST 8'h41
`define SCSC_MSK_SIDE 8'h41
`define SCSC_MSK_INSET 8'h01
`define SCSC_MSK_PULSE 8'hFF
`define SCSC_MSK_BOOST 8'hFF
`define SCSC_MSK_OUTSET 8'h0F

// Field positions
`define SCSC_BIT_EN 6
`define SCSC_BIT_PICK 0
`define SCSC_BIT_TERM_IN 0
`define SCSC_BIT_DRIVE 0
`define SCSC_BIT_TERM_OUT 1
`define SCSC_BIT_EMPH_LO 2
`define SCSC_BIT_EMPH_HI 3

// Timing
`define SCSC_CLK_KHZ 125000
`define SCSC_PULSE_MS 100
`define SCSC_UPD_US 10

`endif

//--- verilog/scsc_top.v
// Two-wire configuration slave with delayed register application for the link switch
//
// Contract
// R01 - Reset low returns every configuration register to its default value.
// R02 - Outside logic keeps reset high in normal operation.
// R03 - Reset selects input A and starts that register's switching delay.
// R04 - Slave address is 100100 plus select-pin level, sent MSB first.
// R05 - Write: address, register offset, data; each byte acknowledged.
// R06 - After write ack, master stops or repeats start for any transfer.
// R07 - Read: repeated start, address with read bit, device acknowledges.
// R08 - Device shifts out addressed register MSB first; master acknowledges.
// R09 - After read, stop or repeated start; reread needs no offset resend.
// R10 - Write effect delayed; delay starts at last data bit's falling clock.
// R11 - During open window writes are stored but outputs hold.
// R12 - Writes never restart window; window end applies latest values.
// R13 - Write after window closed applies at once and opens new window.
// R14 - Fast path register at 0x00, default 0x40, enable bit 6, pick bit 0.
// R15 - Fast path enable 0 turns channels off into standby; 1 on.
// R16 - Fast pick 0 routes A channels, 1 routes B channels.
// R17 - Side switch enable 0 disconnects, 1 connects auxiliary lines.
// R18 - Side pick 0 connects A auxiliary lines, 1 connects B.
// R19 - Pulse register at 0x11, default 0x00, one bit per input channel.
// R20 - Every configuration register is readable and writable over the bus.
// R21 - Pulse bit set drops that input's termination about 100 ms on switch.
// R22 - Boost bit 0 picks 6 dB, 1 picks 12 dB, per input channel.
// R23 - Emphasis code 00,01,10,11 selects 0,2,4,6 dB.
// R24 - Drive bit 0 selects 10 mA, 1 selects 20 mA.
// R25 - Foreign address: no acknowledge, rest of transaction ignored.
// R26 - Undefined bits read zero and ignore writes.
`timescale 1ns/1ps
`include "scsc_map.vh"

module scsc_top #(
    parameter [23:0] UPD_CYC = `SCSC_UPD_US * (`SCSC_CLK_KHZ / 1000),
    parameter [23:0] PULSE_CYC = `SCSC_PULSE_MS * `SCSC_CLK_KHZ
) (
    // Clock and reset
    input wire MCLK,
    input wire RESETN,
    // Two-wire bus
    input wire SCL,
    input wire SDA_I,
    output wire SDA_O,
    output wire SDA_OE,
    // Address select strap
    input wire ADDR_SEL,
    // Fast path controls
    output wire FAST_PATH_ENABLE,
    output wire FAST_PATH_SOURCE_PICK,
    // Side switch controls
    output wire SIDE_SWITCH_ENABLE,
    output wire SIDE_SWITCH_SOURCE_PICK,
    // Input channel controls, bits A0..A3, B3..B0
    output wire [7:0] INPUT_TERM_ON,
    output wire [7:0] INPUT_BOOST_BITS,
    // Output controls
    output wire [1:0] OUTPUT_EMPHASIS_LEVEL,
    output wire OUTPUT_TERM_ON,
    output wire OUTPUT_DRIVE_LEVEL
);

    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_DEV = 4'h1;
    localparam [3:0] ST_ACK_DEV = 4'h2;
    localparam [3:0] ST_REG = 4'h3;
    localparam [3:0] ST_ACK_REG = 4'h4;
    localparam [3:0] ST_WDAT = 4'h5;
    localparam [3:0] ST_ACK_WR = 4'h6;
    localparam [3:0] ST_RDAT = 4'h7;
    localparam [3:0] ST_ACK_RD = 4'h8;
    localparam [2:0] IDX_NONE = 3'h7;
    localparam [2:0] NREG = 3'h6;

    function [2:0] reg_idx;
        input [7:0] ofs;
        begin
            case (ofs)
                `SCSC_OFS_FAST: reg_idx = 3'h0;
                `SCSC_OFS_SIDE: reg_idx = 3'h1;
                `SCSC_OFS_INSET: reg_idx = 3'h2;
                `SCSC_OFS_PULSE: reg_idx = 3'h3;
                `SCSC_OFS_BOOST: reg_idx = 3'h4;
                `SCSC_OFS_OUTSET: reg_idx = 3'h5;
                default: reg_idx = IDX_NONE;
            endcase
        end
    endfunction

    function [7:0] reg_mask;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: reg_mask = `SCSC_MSK_FAST;
                3'h1: reg_mask = `SCSC_MSK_SIDE;
                3'h2: reg_mask = `SCSC_MSK_INSET;
                3'h3: reg_mask = `SCSC_MSK_PULSE;
                3'h4: reg_mask = `SCSC_MSK_BOOST;
                3'h5: reg_mask = `SCSC_MSK_OUTSET;
                default: reg_mask = 8'h00;
            endcase
        end
    endfunction

    function [7:0] reg_rst;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: reg_rst = `SCSC_RST_FAST;
                3'h1: reg_rst = `SCSC_RST_SIDE;
                3'h2: reg_rst = `SCSC_RST_INSET;
                3'h3: reg_rst = `SCSC_RST_PULSE;
                3'h4: reg_rst = `SCSC_RST_BOOST;
                3'h5: reg_rst = `SCSC_RST_OUTSET;
                default: reg_rst = 8'h00;
            endcase
        end
    endfunction

    // Pin synchronisers
    reg scl_m_q, scl_s_q, scl_p_q;
    reg sda_m_q, sda_s_q, sda_p_q;
    reg adr_m_q, adr_s_q;

    always @(posedge MCLK) begin
        if (!RESETN) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
            sda_p_q <= 1'b1;
            adr_m_q <= 1'b0;
            adr_s_q <= 1'b0;
        end else begin
            scl_m_q <= SCL;
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= SDA_I;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
            adr_m_q <= ADDR_SEL;
            adr_s_q <= adr_m_q;
        end
    end

    wire scl_rise = scl_s_q & ~scl_p_q;
    wire scl_fall = ~scl_s_q & scl_p_q;
    wire bus_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
    wire bus_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

    // Register storage: written value, applied value, window counter
    reg [7:0] shadow_q [0:5];
    reg [7:0] appl_q [0:5];
    reg [23:0] win_q [0:5];

    // Serial engine
    reg [3:0] state_q;
    reg [3:0] cnt_q;
    reg [7:0] sr_q;
    reg [7:0] ptr_q;
    reg [7:0] tx_q;
    reg rw_q;
    reg nack_q;
    reg oe_q;
    reg wr_stb_q;
    reg [7:0] wdat_q;

    wire [2:0] ptr_idx = reg_idx(ptr_q);
    wire [7:0] rd_val = (ptr_idx == IDX_NONE) ? 8'h00 : shadow_q[ptr_idx];

    // Open drain: only ever pulls low
    assign SDA_O = 1'b0;
    assign SDA_OE = oe_q;

    always @(posedge MCLK) begin
        if (!RESETN) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sr_q <= 8'h00;
            ptr_q <= 8'h00;
            tx_q <= 8'h00;
            rw_q <= 1'b0;
            nack_q <= 1'b1;
            oe_q <= 1'b0;
            wr_stb_q <= 1'b0;
            wdat_q <= 8'h00;
        end else begin
            wr_stb_q <= 1'b0;
            if (bus_start) begin
                state_q <= ST_DEV;
                cnt_q <= 4'h0;
                oe_q <= 1'b0;
            end else if (bus_stop) begin
                state_q <= ST_IDLE;
                oe_q <= 1'b0;
            end else if (scl_rise) begin
                case (state_q)
                    ST_DEV, ST_REG, ST_WDAT: begin
                        sr_q <= {sr_q[6:0], sda_s_q};
                        cnt_q <= cnt_q + 4'h1;
                    end
                    ST_RDAT: cnt_q <= cnt_q + 4'h1;
                    ST_ACK_RD: nack_q <= sda_s_q; // R08
                    default: ;
                endcase
            end else if (scl_fall) begin
                case (state_q)
                    ST_DEV: begin
                        if (cnt_q == 4'h8) begin
                            if (sr_q[7:1] == {`SCSC_DEV_ADR_HI, adr_s_q}) begin // R04
                                oe_q <= 1'b1;
                                rw_q <= sr_q[0];
                                state_q <= ST_ACK_DEV;
                            end else begin
                                state_q <= ST_IDLE; // R25
                            end
                        end
                    end
                    ST_ACK_DEV: begin
                        cnt_q <= 4'h0;
                        if (rw_q) begin
                            // Reread keeps the last offset
                            tx_q <= rd_val; // R07 R09
                            oe_q <= ~rd_val[7]; // R08
                            state_q <= ST_RDAT;
                        end else begin
                            oe_q <= 1'b0;
                            state_q <= ST_REG; // R05
                        end
                    end
                    ST_REG: begin
                        if (cnt_q == 4'h8) begin
                            ptr_q <= sr_q;
                            oe_q <= 1'b1; // R05
                            state_q <= ST_ACK_REG;
                        end
                    end
                    ST_ACK_REG: begin
                        oe_q <= 1'b0;
                        cnt_q <= 4'h0;
                        state_q <= ST_WDAT;
                    end
                    ST_WDAT: begin
                        if (cnt_q == 4'h8) begin
                            wr_stb_q <= 1'b1; // R10
                            wdat_q <= sr_q;
                            oe_q <= 1'b1; // R05
                            state_q <= ST_ACK_WR;
                        end
                    end
                    ST_ACK_WR: begin
                        // Only a start or stop may follow
                        oe_q <= 1'b0;
                        state_q <= ST_IDLE; // R06
                    end
                    ST_RDAT: begin
                        if (cnt_q == 4'h8) begin
                            oe_q <= 1'b0;
                            state_q <= ST_ACK_RD;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6]; // R08
                        end
                    end
                    ST_ACK_RD: begin
                        cnt_q <= 4'h0;
                        if (nack_q) begin
                            state_q <= ST_IDLE; // R09
                        end else begin
                            tx_q <= rd_val;
                            oe_q <= ~rd_val[7];
                            state_q <= ST_RDAT;
                        end
                    end
                    default: oe_q <= 1'b0;
                endcase
            end
        end
    end

    // Delayed application, one window per register
    wire [2:0] wr_idx = reg_idx(ptr_q);
    integer i;

    always @(posedge MCLK) begin
        for (i = 0; i < NREG; i = i + 1) begin
            if (!RESETN) begin
                shadow_q[i] <= reg_rst(i[2:0]); // R01
                appl_q[i] <= reg_rst(i[2:0]);
                win_q[i] <= (i == 0) ? UPD_CYC : 24'h000000; // R03
            end else if (wr_stb_q && wr_idx == i[2:0]) begin
                shadow_q[i] <= wdat_q & reg_mask(i[2:0]); // R20 R26
                if (win_q[i] == 24'h000000) begin
                    appl_q[i] <= wdat_q & reg_mask(i[2:0]); // R13
                    win_q[i] <= UPD_CYC;
                end
                // Open window keeps counting down, not restarted
                else begin
                    win_q[i] <= win_q[i] - 24'h000001; // R12
                    if (win_q[i] == 24'h000001) begin
                        appl_q[i] <= wdat_q & reg_mask(i[2:0]); // R12
                    end
                end
            end else if (win_q[i] != 24'h000000) begin
                win_q[i] <= win_q[i] - 24'h000001; // R11
                if (win_q[i] == 24'h000001) begin
                    appl_q[i] <= shadow_q[i]; // R12
                end
            end
        end
    end

    // Termination pulse on each applied fast path source change
    reg pick_p_q;
    reg [23:0] pulse_q;
    wire fast_pick = appl_q[0][`SCSC_BIT_PICK];

    always @(posedge MCLK) begin
        if (!RESETN) begin
            pick_p_q <= 1'b0;
            pulse_q <= 24'h000000;
        end else begin
            pick_p_q <= fast_pick;
            if (pick_p_q != fast_pick) begin
                pulse_q <= PULSE_CYC; // R21
            end else if (pulse_q != 24'h000000) begin
                pulse_q <= pulse_q - 24'h000001;
            end
        end
    end

    // Limitation: pulse length fixed by parameter, not trimmed
    wire [7:0] pulse_drop = (pulse_q != 24'h000000) ? appl_q[3] : 8'h00;

    assign FAST_PATH_ENABLE = appl_q[0][`SCSC_BIT_EN]; // R14 R15
    assign FAST_PATH_SOURCE_PICK = fast_pick; // R16
    assign SIDE_SWITCH_ENABLE = appl_q[1][`SCSC_BIT_EN]; // R17
    assign SIDE_SWITCH_SOURCE_PICK = appl_q[1][`SCSC_BIT_PICK]; // R18
    assign INPUT_TERM_ON = {8{appl_q[2][`SCSC_BIT_TERM_IN]}} & ~pulse_drop; // R19 R21
    assign INPUT_BOOST_BITS = appl_q[4]; // R22
    assign OUTPUT_EMPHASIS_LEVEL = appl_q[5][`SCSC_BIT_EMPH_HI:`SCSC_BIT_EMPH_LO]; // R23
    assign OUTPUT_TERM_ON = appl_q[5][`SCSC_BIT_TERM_OUT];
    assign OUTPUT_DRIVE_LEVEL = appl_q[5][`SCSC_BIT_DRIVE]; // R24

endmodule

//--- bench/scsc_sva.sv
// Port-level assertion checker for the switch control slave
`timescale 1ns/1ps
module scsc_sva #(
    parameter [23:0] PULSE_CYC = 24'h32
) (
    // Clock and reset
    input wire MCLK,
    input wire RESETN,
    // Bus pins
    input wire SCL,
    input wire SDA_O,
    input wire SDA_OE,
    // Applied controls
    input wire FAST_PATH_ENABLE,
    input wire FAST_PATH_SOURCE_PICK,
    input wire SIDE_SWITCH_ENABLE,
    input wire SIDE_SWITCH_SOURCE_PICK,
    input wire [7:0] INPUT_TERM_ON,
    input wire [7:0] INPUT_BOOST_BITS,
    input wire [1:0] OUTPUT_EMPHASIS_LEVEL,
    input wire OUTPUT_TERM_ON,
    input wire OUTPUT_DRIVE_LEVEL
);
    default clocking cb @(posedge MCLK); endclocking
    int cnt_q;
    reg pick_q;
    // Saturating count since the last source switch; margin covers sync lag
    always @(posedge MCLK) begin
        pick_q <= FAST_PATH_SOURCE_PICK;
        if (!RESETN || pick_q != FAST_PATH_SOURCE_PICK) begin
            cnt_q <= 0;
        end else if (cnt_q < PULSE_CYC + 9) begin
            cnt_q <= cnt_q + 1;
        end
    end
    sequence rst_rel;
        !RESETN ##1 RESETN;
    endsequence
    rst_fast_a: assert property (!RESETN |=> FAST_PATH_ENABLE && !FAST_PATH_SOURCE_PICK
        && SIDE_SWITCH_ENABLE && !SIDE_SWITCH_SOURCE_PICK) else $error("mode defaults");
    rst_out_a: assert property (!RESETN |=> OUTPUT_TERM_ON && OUTPUT_DRIVE_LEVEL
        && OUTPUT_EMPHASIS_LEVEL == 2'h0 && INPUT_BOOST_BITS == 8'h00
        && INPUT_TERM_ON == 8'hFF) else $error("output defaults");
    rst_pick_a: assert property (rst_rel |-> !FAST_PATH_SOURCE_PICK [*8])
        else $error("source left A after reset");
    rst_sda_a: assert property (!RESETN |=> !SDA_OE) else $error("bus driven in reset");
    open_drain_a: assert property (disable iff (!RESETN) SDA_O == 1'b0)
        else $error("data pin driven high");
    sda_stable_a: assert property (disable iff (!RESETN) $changed(SDA_OE) |-> !SCL)
        else $error("data changed with clock high");
    ack_bound_a: assert property (disable iff (!RESETN)
        $rose(SDA_OE) |-> ##[1:200] !SDA_OE) else $error("data held low too long");
    term_pulse_a: assert property (disable iff (!RESETN) cnt_q == PULSE_CYC + 9
        |-> INPUT_TERM_ON == 8'h00 || INPUT_TERM_ON == 8'hFF) else $error("pulse too long");
endmodule
bind scsc_top scsc_sva #(.PULSE_CYC(PULSE_CYC)) u_sva (.MCLK(MCLK), .RESETN(RESETN),
    .SCL(SCL), .SDA_O(SDA_O), .SDA_OE(SDA_OE), .FAST_PATH_ENABLE(FAST_PATH_ENABLE),
    .FAST_PATH_SOURCE_PICK(FAST_PATH_SOURCE_PICK), .SIDE_SWITCH_ENABLE(SIDE_SWITCH_ENABLE),
    .SIDE_SWITCH_SOURCE_PICK(SIDE_SWITCH_SOURCE_PICK), .INPUT_TERM_ON(INPUT_TERM_ON),
    .INPUT_BOOST_BITS(INPUT_BOOST_BITS), .OUTPUT_EMPHASIS_LEVEL(OUTPUT_EMPHASIS_LEVEL),
    .OUTPUT_TERM_ON(OUTPUT_TERM_ON), .OUTPUT_DRIVE_LEVEL(OUTPUT_DRIVE_LEVEL));

//--- bench/scsc_mstr.sv
// Two-wire bus master model facing the switch control slave
`timescale 1ns/1ps
module scsc_mstr (
    // Slave pull-down request
    input wire sda_oe,
    // Wire levels
    output wire scl,
    output wire sda
);
    reg scl_q = 1'b1;
    reg sda_q = 1'b1;
    assign scl = scl_q;
    // Pulled up: released means high, either party low wins
    assign sda = sda_q & ~sda_oe;
    task start;
        sda_q = 1'b1;
        #31.25 scl_q = 1'b1;
        #31.25 sda_q = 1'b0;
        #31.25 scl_q = 1'b0;
    endtask
    task stop;
        sda_q = 1'b0;
        #31.25 scl_q = 1'b1;
        #31.25 sda_q = 1'b1;
        #31.25;
    endtask
    // Eight bits MSB first, then the acknowledge slot
    task xfer(input [7:0] d, input ak, output [7:0] r, output k);
        integer i;
        for (i = 8; i >= 0; i = i - 1) begin
            #15.625 sda_q = (i == 0) ? ak : d[7];
            d = d << 1;
            #15.625 scl_q = 1'b1;
            #31.25;
            if (i > 0) begin
                r = {r[6:0], sda};
            end else begin
                k = sda;
            end
            #31.25 scl_q = 1'b0;
            #31.25;
        end
    endtask
endmodule

//--- bench/scsc_tb_top.sv
// Self-checking bench for the switch control slave
`timescale 1ns/1ps
`include "scsc_map.vh"
module scsc_tb_top;
    reg mclk = 1'b0;
    reg resetn = 1'b0;
    reg addr_sel = 1'b0;
    wire scl, sda, sda_o, sda_oe, fpe, fps, sse, sss, oto, odl;
    wire [7:0] ito, ibb;
    wire [1:0] oel;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    int ofs_t[7] = '{0, 1, 16, 17, 19, 32, 5};
    int rst_t[7] = '{64, 64, 1, 0, 0, 3, 0};
    int msk_t[7] = '{65, 65, 1, 255, 255, 15, 0};
    int mdl[7];
    int m;
    logic [7:0] q;
    logic a;
    scsc_top #(.UPD_CYC(24'h258), .PULSE_CYC(24'h32)) DUT (.MCLK(mclk), .RESETN(resetn),
        .SCL(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(addr_sel),
        .FAST_PATH_ENABLE(fpe), .FAST_PATH_SOURCE_PICK(fps), .SIDE_SWITCH_ENABLE(sse),
        .SIDE_SWITCH_SOURCE_PICK(sss), .INPUT_TERM_ON(ito), .INPUT_BOOST_BITS(ibb),
        .OUTPUT_EMPHASIS_LEVEL(oel), .OUTPUT_TERM_ON(oto), .OUTPUT_DRIVE_LEVEL(odl));
    scsc_mstr u_m (.sda_oe(sda_oe), .scl(scl), .sda(sda));
    always #4 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail_count++;
            complete_run;
        end
    end
    task complete_run;
        $display("Errors %0d, compares %0d", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Look at settled outputs only, on the falling edge, never in the time step of a rising clock edge
    task chk(input logic [7:0] got, input int exp);
        @(negedge mclk);
        compares++;
        if (got !== exp[7:0]) begin
            fail_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp[7:0]);
        end
    endtask
    task xa(input int d, input int ack);
        u_m.xfer(d[7:0], 1'b1, q, a);
        chk({7'h00, a}, ack);
    endtask
    task dev(input bit rd);
        u_m.start;
        xa({`SCSC_DEV_ADR_HI, addr_sel, rd}, 0);
    endtask
    task wr(input int i, input int d, input bit p);
        dev(1'b0);
        xa(ofs_t[i], 0);
        xa(d, 0);
        mdl[i] = d & msk_t[i];
        if (p) begin
            u_m.stop;
        end
    endtask
    // Master refuses the byte so the slave lets go before the next condition
    task rd(input int i, input bit again);
        if (!again) begin
            dev(1'b0);
            xa(ofs_t[i], 0);
        end
        dev(1'b1);
        u_m.xfer(8'hFF, 1'b1, q, a);
        chk(q, mdl[i]);
    endtask
    task chk_out;
        chk({1'b0, fpe, 5'h00, fps}, mdl[0]);
        chk({1'b0, sse, 5'h00, sss}, mdl[1]);
        chk(ito, mdl[2][0] ? 255 : 0);
        chk(ibb, mdl[4]);
        chk({4'h0, oel, oto, odl}, mdl[5]);
    endtask
    task rst;
        @(negedge mclk);
        resetn = 1'b0;
        repeat (10) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        foreach (mdl[i]) mdl[i] = rst_t[i];
    endtask
    initial begin
        m = $urandom(32'hE1C8C051);
        rst;
        chk_out;
        wr(0, 65, 1);
        chk({7'h00, fps}, 0);
        repeat (250) @(negedge mclk);
        chk({7'h00, fps}, 1);
        m = $urandom & 255;
        wr(3, m, 1);
        repeat (700) @(negedge mclk);
        wr(0, 64, 1);
        chk(ito, ~m);
        repeat (60) @(negedge mclk);
        chk_out;
        for (int s = 0; s < 2; s++) begin
            @(negedge mclk);
            addr_sel = s[0];
            repeat (4) @(negedge mclk);
            foreach (ofs_t[i]) begin
                wr(i, $urandom, 0);
                rd(i, 0);
                rd(i, 1);
                u_m.stop;
            end
        end
        repeat (700) @(negedge mclk);
        chk_out;
        u_m.start;
        xa({`SCSC_DEV_ADR_HI, ~addr_sel, 1'b0}, 1);
        xa(ofs_t[5], 1);
        xa(0, 1);
        u_m.stop;
        rd(5, 0);
        u_m.stop;
        repeat (700) @(negedge mclk);
        m = $urandom & 15;
        wr(5, m, 0);
        chk({4'h0, oel, oto, odl}, m);
        wr(5, m ^ 15, 1);
        chk({4'h0, oel, oto, odl}, m);
        repeat (250) @(negedge mclk);
        chk({4'h0, oel, oto, odl}, m ^ 15);
        rst;
        foreach (ofs_t[i]) begin
            rd(i, 0);
            u_m.stop;
        end
        complete_run;
    end
endmodule
